/* common/sync_serial_pkg.sv */
package sync_serial_pkg;

	// ==========================================================
	// Widths
	// ==========================================================
	localparam int WORD_W = 16;
	localparam int KCNT_W = 6;
	localparam int HALF_W = 15;

	// ==========================================================
	// Format and configuration encodings
	// ==========================================================
	localparam logic FMT_FRAME_PULSE = 1'b0;
	localparam logic FMT_SPI = 1'b1;
	localparam logic [3:0] MIN_WORD_SIZE = 4'h3;
	localparam logic [7:0] MIN_PRESCALE = 8'h02;

	// Half-period event indices within a word (relative to 2N)
	localparam logic [KCNT_W-1:0] K_ONE = 6'h01;
	localparam logic [KCNT_W-1:0] K_TWO = 6'h02;
	localparam logic [KCNT_W-1:0] K_THREE = 6'h03;
	localparam logic [KCNT_W-1:0] K_FOUR = 6'h04;

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic RST_CLK = 1'b0;
	localparam logic RST_FRAME = 1'b0;
	localparam logic RST_TX = 1'b0;
	localparam logic RST_OE_N = 1'b1;
	localparam logic [WORD_W-1:0] RST_WORD = 16'h0000;
	localparam logic [KCNT_W-1:0] RST_K = 6'h00;
	localparam logic [HALF_W-1:0] RST_HALF = 15'h0000;

	// ==========================================================
	// Sequencer states
	// ==========================================================
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01
	} state_t;

endpackage

/* common/divider_if.sv */
`timescale 1ns/1ps

interface divider_if;
	logic run;
	logic [7:0] prescale;
	logic [7:0] rate;
	logic tick;

	modport seq(output run, output prescale, output rate, input tick);
	modport div(input run, input prescale, input rate, output tick);
endinterface

/* logic/half_period_divider.sv */
`timescale 1ns/1ps

module half_period_divider
	import sync_serial_pkg::*;
(
	input wire logic clock_i,
	input wire logic resetn_i,
	divider_if.div dv
);

	logic [HALF_W-1:0] cnt;
	logic [7:0] pre;
	logic [15:0] prod;
	logic [HALF_W-1:0] half_m1;

	// ==========================================================
	// Half-period length
	// ==========================================================
	// Odd or too small prescale is forced even and at least two
	// serial clock division
	always_comb begin
		pre = (dv.prescale < MIN_PRESCALE) ? MIN_PRESCALE : dv.prescale;
		prod = 16'(pre[7:1]) * (16'(dv.rate) + 16'h0001);
		half_m1 = HALF_W'(prod - 16'h0001);
	end

	// Tick once per half serial period while running
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt <= RST_HALF;
			dv.tick <= 1'b0;
		end else if (!dv.run) begin
			cnt <= RST_HALF;
			dv.tick <= 1'b0;
		end else if (cnt == RST_HALF) begin
			cnt <= half_m1;
			dv.tick <= 1'b1;
		end else begin
			cnt <= cnt - 15'h0001;
			dv.tick <= 1'b0;
		end
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	chk_tick_spacing_gap: assert property (
		dv.tick && dv.run && $stable(half_m1) && half_m1 != RST_HALF
		|=> !dv.tick)
		else $error("divider ticked on adjacent cycles");

endmodule

/* logic/sync_serial_frame_formats.sv */
// Contract
// - Frame-pulse idle: clock, frame low, transmit floating
// - Frame-pulse: frame high one period, load word
// - Frame-pulse: next rising edge drives word MSB
// - Both sides sample bits on falling edge
// - Push received word on following rising edge
// - Polarity bit sets idle SPI clock level
// - Phase bit picks first or second edge
// - SPI idle: frame high, tx low, clock driver
// - Master starts: frame low, enable transmit driver
// - Phase0 pol0: bit half period, rise sample
// - Phase0 pol1: bit half period, fall sample
// - Phase1 pol0: bit with first rising edge
// - Phase1 pol1: bit with first falling edge
// - Single word: frame idle one period later
// - Phase zero bursts pulse frame between words
// - Phase one bursts hold frame low throughout
// - Burst end: frame idle one period later
// - Words MSB first, four to sixteen bits
// - Serial clock divided by prescale times rate; code divides by prescale times (rate plus one)
`timescale 1ns/1ps

module sync_serial_frame_formats
	import sync_serial_pkg::*;
(
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic enable_i,
	input wire logic master_i,
	input wire logic format_i,
	input wire logic clock_polarity_bit_i,
	input wire logic clock_phase_bit_i,
	input wire logic [3:0] word_size_i,
	input wire logic [7:0] prescale_divisor_i,
	input wire logic [7:0] clock_rate_field_i,
	input wire logic tx_valid_i,
	input wire logic [WORD_W-1:0] tx_data_i,
	output logic tx_pop_o,
	output logic [WORD_W-1:0] rx_data_o,
	output logic rx_valid_o,
	output logic busy_o,
	output logic serial_clock_pin_o,
	output logic serial_clock_pin_oe_n_o,
	output logic frame_select_pin_o,
	output logic frame_select_pin_oe_n_o,
	output logic serial_tx_pin_o,
	output logic serial_tx_pin_oe_n_o,
	input wire logic serial_rx_pin_i
);

	// ==========================================================
	// Helpers
	// ==========================================================
	// Twice the word length, i.e. half periods spent on data
	function automatic logic [KCNT_W-1:0] two_n(input logic [3:0] size);
		return KCNT_W'({size, 1'b0}) + K_TWO;
	endfunction

	// Mask of the valid low bits of a word of the given size
	function automatic logic [WORD_W-1:0] word_mask(input logic [3:0] size);
		logic [WORD_W-1:0] m;
		m = RST_WORD;
		for (int i = 0; i < WORD_W; i++) begin
			if (i <= int'(size)) begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction

	state_t state;
	logic spi_q;
	logic cpha_q;
	logic [3:0] size_q;
	logic [KCNT_W-1:0] k;
	logic [WORD_W-1:0] tx_sh;
	logic [WORD_W-1:0] rx_sh;
	logic [3:0] size_in;
	logic [WORD_W-1:0] aligned;
	logic tick;
	logic running;
	logic more;
	logic start_ok;
	logic reload;
	logic finish;
	logic load;
	logic toggle_ev;
	logic sample_ev;
	logic shift_ev;
	logic show_msb;
	logic push_ev;
	logic [KCNT_W-1:0] kn;
	logic [KCNT_W-1:0] tn;

	divider_if dv ();

	// ==========================================================
	// Bit-rate divider
	// ==========================================================
	// Divider runs only while enabled or finishing a word
	assign dv.run = enable_i || (state == ST_RUN);
	assign dv.prescale = prescale_divisor_i;
	assign dv.rate = clock_rate_field_i;
	assign tick = dv.tick;

	half_period_divider u_div (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.dv(dv)
	);

	// ==========================================================
	// Event decode per half serial period
	// ==========================================================
	// Short sizes are raised to four bits; every word is left-aligned to bit 15
	always_comb begin
		size_in = (word_size_i < MIN_WORD_SIZE) ? MIN_WORD_SIZE : word_size_i;
		aligned = tx_data_i << (4'hf - size_in);
		running = (state == ST_RUN);
		kn = k + K_ONE;
		tn = two_n(size_q);
		more = enable_i && tx_valid_i;
		start_ok = tick && !running && enable_i && master_i && tx_valid_i;
		toggle_ev = 1'b0;
		sample_ev = 1'b0;
		shift_ev = 1'b0;
		show_msb = 1'b0;
		push_ev = 1'b0;
		reload = 1'b0;
		if (!spi_q) begin
			toggle_ev = kn <= tn + K_ONE;
			sample_ev = kn[0] && kn >= K_THREE && kn <= tn + K_ONE;
			shift_ev = !kn[0] && kn >= K_FOUR && kn <= tn;
			show_msb = kn == K_TWO;
			push_ev = kn == tn + K_TWO;
			reload = push_ev && more;
		end else begin
			if (cpha_q) begin
				toggle_ev = kn >= K_ONE && kn <= tn;
			end else begin
				toggle_ev = kn >= K_TWO && kn <= tn + K_ONE;
			end
			sample_ev = !kn[0] && kn >= K_TWO && kn <= tn;
			shift_ev = kn[0] && kn >= K_THREE && kn < tn;
			show_msb = kn == K_ONE;
			push_ev = kn == tn + K_ONE;
			reload = cpha_q && push_ev && more;
		end
		toggle_ev = toggle_ev && tick && running;
		sample_ev = sample_ev && tick && running;
		shift_ev = shift_ev && tick && running;
		show_msb = show_msb && tick && running;
		push_ev = push_ev && tick && running;
		reload = reload && tick && running;
		finish = tick && running && !reload && kn == tn + K_TWO;
		load = start_ok || reload;
	end

	// ==========================================================
	// Sequencer state and half-period counter
	// ==========================================================
	// master start from idle
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= ST_IDLE;
			k <= RST_K;
		end else if (start_ok) begin
			state <= ST_RUN;
			k <= RST_K;
		end else if (reload) begin
			k <= spi_q ? K_ONE : RST_K;
		end else if (finish) begin
			state <= ST_IDLE;
			k <= kn;
		end else if (tick && running) begin
			k <= kn;
		end
	end

	// Format, phase and word size are captured per word so a change cannot tear one
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			spi_q <= FMT_FRAME_PULSE;
			cpha_q <= 1'b0;
			size_q <= MIN_WORD_SIZE;
		end else if (load) begin
			spi_q <= format_i;
			cpha_q <= clock_phase_bit_i;
			size_q <= size_in;
		end
	end

	// ==========================================================
	// Shift registers
	// ==========================================================
	// MSB first; transmit left aligned, receive right aligned
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tx_sh <= RST_WORD;
			rx_sh <= RST_WORD;
		end else begin
			if (load) begin
				tx_sh <= aligned;
			end else if (shift_ev) begin
				tx_sh <= tx_sh << 1;
			end
			if (sample_ev) begin
				rx_sh <= {rx_sh[WORD_W-2:0], serial_rx_pin_i};
			end
		end
	end

	// ==========================================================
	// Receive hand-off and transmit pop
	// ==========================================================
	// word pushed after last sample
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_data_o <= RST_WORD;
			rx_valid_o <= 1'b0;
			tx_pop_o <= 1'b0;
			busy_o <= 1'b0;
		end else begin
			rx_valid_o <= push_ev;
			if (push_ev) begin
				rx_data_o <= rx_sh & word_mask(size_q);
			end
			tx_pop_o <= load;
			busy_o <= (running && !finish) || start_ok;
		end
	end

	// ==========================================================
	// Pin drivers
	// ==========================================================
	// Output enables are low while driving; slaves never drive clock
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			serial_clock_pin_oe_n_o <= RST_OE_N;
			frame_select_pin_oe_n_o <= RST_OE_N;
		end else begin
			serial_clock_pin_oe_n_o <= !master_i;
			frame_select_pin_oe_n_o <= !master_i;
		end
	end

	// Clock, frame and transmit levels follow the half-period events
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			serial_clock_pin_o <= RST_CLK;
			frame_select_pin_o <= RST_FRAME;
			serial_tx_pin_o <= RST_TX;
			serial_tx_pin_oe_n_o <= RST_OE_N;
		end else if (!running && !start_ok) begin
			serial_clock_pin_o <= format_i ? clock_polarity_bit_i : 1'b0;
			frame_select_pin_o <= format_i;
			serial_tx_pin_o <= 1'b0;
			serial_tx_pin_oe_n_o <= !(format_i && master_i);
		end else if (start_ok) begin
			if (format_i) begin
				frame_select_pin_o <= 1'b0;
				serial_tx_pin_oe_n_o <= 1'b0;
			end else begin
				serial_clock_pin_o <= 1'b1;
				frame_select_pin_o <= 1'b1;
			end
		end else if (reload && !spi_q) begin
			serial_clock_pin_o <= 1'b1;
			frame_select_pin_o <= 1'b1;
		end else if (reload) begin
			serial_clock_pin_o <= !serial_clock_pin_o;
			serial_tx_pin_o <= aligned[WORD_W-1];
		end else if (tick) begin
			if (toggle_ev) begin
				serial_clock_pin_o <= !serial_clock_pin_o;
			end
			if (show_msb) begin
				serial_tx_pin_o <= tx_sh[WORD_W-1];
				serial_tx_pin_oe_n_o <= 1'b0;
				if (!spi_q) begin
					frame_select_pin_o <= 1'b0;
				end
			end
			if (shift_ev) begin
				serial_tx_pin_o <= tx_sh[WORD_W-2];
			end
			if (finish) begin
				frame_select_pin_o <= spi_q;
				serial_tx_pin_o <= 1'b0;
				serial_tx_pin_oe_n_o <= spi_q ? 1'b0 : 1'b1;
			end
		end
	end

	// ==========================================================
	// Checks
	// ==========================================================
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	chk_pulse_idle_pins: assert property (
		!running && !start_ok && format_i == FMT_FRAME_PULSE
		|=> !serial_clock_pin_o && !frame_select_pin_o
		&& serial_tx_pin_oe_n_o)
		else $error("frame-pulse idle levels wrong");

	chk_spi_idle_pins: assert property (
		!running && !start_ok && format_i == FMT_SPI
		|=> serial_clock_pin_o == $past(clock_polarity_bit_i)
		&& frame_select_pin_o && !serial_tx_pin_o)
		else $error("spi idle levels wrong");

	chk_pulse_frame_len: assert property (
		running && !spi_q && $fell(frame_select_pin_o) |-> k == K_TWO)
		else $error("frame pulse not one serial period");

	chk_pulse_msb_out: assert property (
		running && !spi_q && $fell(frame_select_pin_o)
		|-> serial_tx_pin_o == tx_sh[WORD_W-1] && !serial_tx_pin_oe_n_o)
		else $error("msb not driven after frame pulse");

	chk_rx_push_time: assert property (
		rx_valid_o |-> $past(tick) && $past(k) + K_ONE
		== $past(tn) + ($past(spi_q) ? K_ONE : K_TWO))
		else $error("receive push at wrong half period");

	chk_phase0_first_bit: assert property (
		running && spi_q && !cpha_q && tick && kn == K_ONE
		|=> $stable(serial_clock_pin_o) && serial_tx_pin_o == tx_sh[WORD_W-1])
		else $error("phase zero first bit timing wrong");

	chk_phase1_first_edge: assert property (
		running && spi_q && cpha_q && tick && kn == K_ONE
		|=> serial_clock_pin_o != $past(serial_clock_pin_o))
		else $error("phase one first edge missing");

	// The word has already ended when the frame is seen high again
	chk_spi_frame_end: assert property (
		$past(running) && spi_q && $rose(frame_select_pin_o)
		|-> $past(k) + K_ONE == $past(tn) + K_TWO)
		else $error("frame released at wrong time");

	chk_phase1_frame_hold: assert property (
		running && spi_q && cpha_q && k != RST_K && k <= tn + K_ONE
		|-> !frame_select_pin_o)
		else $error("frame rose inside phase one burst");

endmodule

/* tb/serial_peer_model.sv */
`timescale 1ns/1ps

// ====================
// Off-chip peer: shifts a reply out, captures the device bits
// ====================
module serial_peer_model
	import sync_serial_pkg::*;
(
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic format_i,
	input wire logic pol_i,
	input wire logic phase_i,
	input wire logic [3:0] size_i,
	input wire logic [1:0][WORD_W-1:0] reply_i,
	input wire logic sclk_i,
	input wire logic fss_i,
	input wire logic tx_i,
	output logic rx_o,
	output logic [WORD_W-1:0] got_o,
	output logic got_valid_o
);
	logic last_clk;
	logic last_fss;
	logic fp_live;
	logic nth;
	logic [4:0] cnt;
	logic want;
	logic live;
	logic edge_s;
	logic edge_c;

	// Clock level reached on a sampling edge
	assign want = format_i & (pol_i ~^ phase_i);
	assign live = format_i ? !fss_i : fp_live & !fss_i;
	assign edge_s = (sclk_i != last_clk) && (sclk_i == want);
	assign edge_c = (sclk_i != last_clk) && (sclk_i != want);

	// Released line toggles, so a stale bit never passes for data
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			last_clk <= 1'b0;
			last_fss <= 1'b1;
			fp_live <= 1'b0;
			nth <= 1'b0;
			cnt <= 5'h00;
			rx_o <= 1'b0;
			got_o <= 16'h0000;
			got_valid_o <= 1'b0;
		end else begin
			last_clk <= sclk_i;
			last_fss <= fss_i;
			got_valid_o <= 1'b0;
			if (!format_i && fss_i) begin
				fp_live <= 1'b1;
			end
			// reply bits, MSB first
			// A new reply word is taken only after a whole word ends
			if (!live) begin
				rx_o <= !rx_o;
			end else if (format_i && last_fss) begin
				rx_o <= reply_i[nth][size_i];
			end else if (edge_c) begin
				rx_o <= reply_i[nth][size_i - cnt[3:0]];
			end
			if (live && edge_s) begin
				got_o <= {got_o[WORD_W-2:0], tx_i};
				cnt <= cnt + 5'h01;
				if (cnt[3:0] == size_i) begin
					cnt <= 5'h00;
					got_valid_o <= 1'b1;
					fp_live <= 1'b0;
					nth <= !nth;
				end
			end
		end
	end
endmodule

/* tb/sync_serial_frame_formats_tb.sv */
`timescale 1ns/1ps
`define check_eq(what, exp, got) \
	begin \
		checked++; \
		if ((got) !== (exp)) begin \
			miscompares++; \
			$display("wrong value %s expected %0h seen %0h", what, exp, got); \
		end \
	end

module sync_serial_frame_formats_tb
	import sync_serial_pkg::*;
();
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic enable = 1'b0;
	logic master = 1'b1;
	logic format = 1'b0;
	logic pol = 1'b0;
	logic phase = 1'b0;
	logic tx_valid = 1'b0;
	logic [3:0] size = 4'hf;
	logic [7:0] rate = 8'h00;
	logic [WORD_W-1:0] tx_data = 16'h0000;
	logic [1:0][WORD_W-1:0] reply = '0;
	logic tx_pop, rx_valid, busy, sclk, sclk_oe_n, fss, fss_oe_n;
	logic tx, tx_oe_n, rx, got_valid, fss_q, sclk_q;
	logic [WORD_W-1:0] rx_data, got;
	logic [WORD_W-1:0] rxq[$];
	logic [WORD_W-1:0] gotq[$];
	int checked = 0;
	int miscompares = 0;
	int rises = 0, pops = 0, hi = 0, hi_len = 0;
	int sc = 0, per = 0, since = 0, gap = 0;

	// ====================
	// Clock, design and peer
	// ====================
	always #12.5 clock = ~clock;

	sync_serial_frame_formats uut (.clock_i(clock), .resetn_i(resetn),
		.enable_i(enable), .master_i(master), .format_i(format),
		.clock_polarity_bit_i(pol), .clock_phase_bit_i(phase),
		.word_size_i(size), .prescale_divisor_i(8'h04),
		.clock_rate_field_i(rate), .tx_valid_i(tx_valid),
		.tx_data_i(tx_data), .tx_pop_o(tx_pop), .rx_data_o(rx_data),
		.rx_valid_o(rx_valid), .busy_o(busy),
		.serial_clock_pin_o(sclk), .serial_clock_pin_oe_n_o(sclk_oe_n),
		.frame_select_pin_o(fss), .frame_select_pin_oe_n_o(fss_oe_n),
		.serial_tx_pin_o(tx), .serial_tx_pin_oe_n_o(tx_oe_n),
		.serial_rx_pin_i(rx));

	serial_peer_model peer (.clock_i(clock), .resetn_i(resetn),
		.format_i(format), .pol_i(pol), .phase_i(phase), .size_i(size),
		.reply_i(reply), .sclk_i(sclk), .fss_i(fss), .tx_i(tx),
		.rx_o(rx), .got_o(got), .got_valid_o(got_valid));

	// Line monitor, sampled mid-cycle where outputs are settled
	always @(negedge clock) begin
		fss_q <= fss;
		sclk_q <= sclk;
		hi <= fss ? hi + 1 : 0;
		sc <= (sclk && !sclk_q) ? 1 : sc + 1;
		since <= got_valid ? 1 : since + 1;
		if (!fss && fss_q) hi_len <= hi;
		if (sclk && !sclk_q) per <= sc;
		if (fss && !fss_q) rises <= rises + 1;
		if (fss && !fss_q) gap <= since;
		if (tx_pop) pops <= pops + 1;
		if (rx_valid) rxq.push_back(rx_data);
		if (got_valid) gotq.push_back(got);
	end

	// ====================
	// Tasks
	// ====================
	task automatic summarize();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// Bounded wait for a pop, or for the port to go idle
	task automatic wait_on(input bit idle);
		for (int i = 0; i < 5000; i++) begin
			@(negedge clock);
			if (idle ? busy === 1'b0 : tx_pop === 1'b1) return;
		end
		miscompares++;
		summarize();
	endtask

	task automatic check_idle(input logic spi, input logic level);
		if (spi) begin
			`check_eq("idle clock", level, sclk)
			`check_eq("idle frame", 1'b1, fss)
			`check_eq("idle tx", 1'b0, tx)
			`check_eq("clock driver", 1'b0, sclk_oe_n)
			`check_eq("frame driver", 1'b0, fss_oe_n)
			`check_eq("tx driver", 1'b0, tx_oe_n)
		end else begin
			`check_eq("idle clock", 1'b0, sclk)
			`check_eq("idle frame", 1'b0, fss)
			`check_eq("tx driver", 1'b1, tx_oe_n)
			`check_eq("frame driver", 1'b0, fss_oe_n)
		end
	endtask

	// Two queued words in one format; odd modes use 4-bit words
	task automatic run_mode(input int m);
		int h;
		logic [WORD_W-1:0] mask;
		logic [1:0][WORD_W-1:0] sent;
		h = 2 * (1 + m);
		mask = (m % 2) ? 16'h000f : 16'hffff;
		sent = {16'h5a3c ^ 16'(m), 16'hc3a5 + 16'(m)};
		@(posedge clock);
		enable <= 1'b0;
		format <= (m != 0);
		pol <= (m == 2 || m == 4);
		phase <= (m > 2);
		size <= (m % 2) ? 4'h3 : 4'hf;
		rate <= 8'(m);
		reply <= {16'h0f1e + 16'(m), 16'he1d2 ^ 16'(m)};
		@(posedge clock);
		enable <= 1'b1;
		repeat (4) @(negedge clock);
		check_idle(m != 0, m == 2 || m == 4);
		@(posedge clock);
		rises = 0;
		rxq.delete();
		gotq.delete();
		tx_data <= sent[0];
		tx_valid <= 1'b1;
		wait_on(0);
		@(posedge clock);
		tx_data <= sent[1];
		wait_on(0);
		@(posedge clock);
		tx_valid <= 1'b0;
		wait_on(1);
		repeat (2 * h) @(negedge clock);
		for (int k = 0; k < 2; k++) begin
			`check_eq("rx word", reply[k] & mask, rxq[k])
			`check_eq("peer word", sent[k] & mask, gotq[k] & mask)
		end
		`check_eq("frame rises", (m > 2) ? 1 : 2, rises)
		if (m == 0) `check_eq("pulse width", 2 * h, hi_len)
		else `check_eq("frame return", 2 * h - 1, gap)
		`check_eq("clock period", 2 * h, per)
		check_idle(m != 0, m == 2 || m == 4);
	endtask

	// ====================
	// Main sequence
	// ====================
	initial begin
		repeat (16) @(posedge clock);
		resetn <= 1'b1;
		for (int m = 0; m < 5; m++) begin
			run_mode(m);
		end
		// Queued data with the port off, then as slave: nothing starts
		@(posedge clock);
		enable <= 1'b0;
		tx_valid <= 1'b1;
		pops = 0;
		repeat (40) @(negedge clock);
		`check_eq("disabled pops", 0, pops)
		`check_eq("disabled frame", 1'b1, fss)
		@(posedge clock);
		enable <= 1'b1;
		master <= 1'b0;
		repeat (40) @(negedge clock);
		`check_eq("slave pops", 0, pops)
		`check_eq("slave clock driver", 1'b1, sclk_oe_n)
		`check_eq("slave frame driver", 1'b1, fss_oe_n)
		summarize();
	end
endmodule
